/* File: hw/periodic_timer_pkg.sv */
/*
 * Constants, register map and field layout of the periodic timer.
 * Assumes an AXI4-Lite master with 32-bit data on the same clock.
 */
// Operation
// - Mode 00 selects compare-match output
// - Clear-select low: clear on P, both flags
// - Clear-select high: clear on A, A flag only
// - A value zero: overflow at 3FF, no A flag
// - Compare mode: pin changes only on A match or run rise
// - A match drives pin per output function
// - Function 00 none, 01 low, 10 high, 11 toggle
// - Run rising edge loads initial pin level
// - Mode 11 like compare, pin not driven
// - PWM is mode 10, function 10
// - PWM period from P, zero means 1024
// - Duty at or above period gives 100%
// - PWM raises A and P flags on matches
// - PWM active level, forced levels, inversion
// - PWM counter runs while output forced
// - Single pulse is mode 10, function 11
// - Run rising edge starts pulse and counter
// - External clock rising edge sets run bit
// - A match or run clear ends pulse
// - Pulse counter resets only on run rise
// - Mode 01 capture, source select, run start
// - Capture edge copies counter into A
// - Capture counter free runs, P match clears
// - Capture function 11 disables capture
// - Capture edge: 00 rise, 01 fall, 10 both
// - Output control 0 active low, 1 high
package periodic_timer_pkg;

	localparam int CNT_W = 10;

	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_COMPARE_A = 4'h4;
	localparam logic [3:0] OFF_COMPARE_P = 4'h8;
	localparam logic [3:0] OFF_COUNT = 4'hC;

	localparam int POS_RUN = 8;
	localparam int POS_FLAG_A = 9;
	localparam int POS_FLAG_P = 10;

	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;

	localparam logic [1:0] FUNC_00 = 2'h0;
	localparam logic [1:0] FUNC_01 = 2'h1;
	localparam logic [1:0] FUNC_10 = 2'h2;
	localparam logic [1:0] FUNC_11 = 2'h3;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] mode_sel;
		logic [1:0] out_func;
		logic out_init_level;
		logic out_invert;
		logic capture_source_sel;
		logic clear_select;
	} timer_control_one_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} edge_pair_t;

endpackage : periodic_timer_pkg

/* File: hw/pin_edge_sync.sv */
/*
 * Three-stage pin synchroniser with edge detection.
 * Assumes an asynchronous pin and the system clock.
 */
`timescale 1ns/1ps
module pin_edge_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output periodic_timer_pkg::edge_pair_t edges
);
	logic s1;
	logic s2;
	logic s3;
	logic settled;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Level accepted once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn)
			settled <= 1'b0;
		else if (s2 == s3)
			settled <= s3;
	end

	assign edges = '{rise: s2 & s3 & ~settled, fall: ~s2 & ~s3 & settled};

endmodule : pin_edge_sync

/* File: hw/periodic_timer.sv */
/*
 * Ten-bit periodic timer: compare, timer, PWM, single pulse, capture.
 * Assumes an AXI4-Lite master and a one-cycle count tick from a prescaler.
 */
`timescale 1ns/1ps
module periodic_timer #(
	parameter int CNT_W = periodic_timer_pkg::CNT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_tick,
	input wire logic timer_io_pin_in,
	input wire logic timer_ext_clock_pin,
	output logic timer_io_pin_out,
	output logic timer_io_pin_oe
);
	////////////////////////////////////////////////////////////////////
	periodic_timer_pkg::timer_control_one_t timer_control_one;
	logic [CNT_W-1:0] compare_a_value;
	logic [CNT_W-1:0] compare_p_value;
	logic [CNT_W-1:0] count;
	logic run_bit;
	logic run_prev;
	logic match_a_flag;
	logic match_p_flag;
	logic pin_level;
	periodic_timer_pkg::edge_pair_t io_edges;
	periodic_timer_pkg::edge_pair_t ck_edges;

	pin_edge_sync io_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(timer_io_pin_in),
		.edges(io_edges)
	);

	pin_edge_sync ck_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(timer_ext_clock_pin),
		.edges(ck_edges)
	);

	////////////////////////////////////////////////////////////////////
	// Mode decode
	logic [1:0] mode;
	logic [1:0] func;
	logic is_cmp;
	logic is_pwm;
	logic is_pulse;
	logic is_cap;
	assign mode = timer_control_one.mode_sel;
	assign func = timer_control_one.out_func;
	assign is_cmp = (mode == periodic_timer_pkg::MODE_COMPARE) ||
		(mode == periodic_timer_pkg::MODE_TIMER);
	assign is_pwm = (mode == periodic_timer_pkg::MODE_PWM) &&
		(func != periodic_timer_pkg::FUNC_11);
	assign is_pulse = (mode == periodic_timer_pkg::MODE_PWM) &&
		(func == periodic_timer_pkg::FUNC_11);
	assign is_cap = (mode == periodic_timer_pkg::MODE_CAPTURE);

	logic run_rise;
	assign run_rise = run_bit & ~run_prev;

	////////////////////////////////////////////////////////////////////
	// Comparators, evaluated on a tick so each match is one event
	logic [CNT_W-1:0] count_inc;
	logic hit_a;
	logic hit_p;
	logic overflow;
	logic match_a;
	logic match_p;
	logic clear_cnt;
	assign count_inc = count + CNT_W'(1);
	assign overflow = (count == {CNT_W{1'b1}});
	assign hit_a = (count_inc == compare_a_value) ||
		(compare_a_value == '0 && overflow);
	assign hit_p = (count_inc == compare_p_value) ||
		(compare_p_value == '0 && overflow);
	assign match_a = run_bit && count_tick && hit_a &&
		!(is_cmp && compare_a_value == '0) && !is_cap;
	assign match_p = run_bit && count_tick && hit_p &&
		!(is_cmp && timer_control_one.clear_select) && !is_pulse;

	always_comb begin
		clear_cnt = 1'b0;
		if (is_cmp) begin
			if (timer_control_one.clear_select)
				clear_cnt = hit_a;
			else
				clear_cnt = hit_p;
		end else if (is_pwm || is_cap) begin
			clear_cnt = hit_p;
		end
	end

	// Capture edge selection
	periodic_timer_pkg::edge_pair_t cap_src;
	logic cap_event;
	assign cap_src = timer_control_one.capture_source_sel ? ck_edges :
		io_edges;
	always_comb begin
		unique case (func)
			periodic_timer_pkg::FUNC_00: cap_event = cap_src.rise;
			periodic_timer_pkg::FUNC_01: cap_event = cap_src.fall;
			periodic_timer_pkg::FUNC_10:
				cap_event = cap_src.rise | cap_src.fall;
			periodic_timer_pkg::FUNC_11: cap_event = 1'b0;
		endcase
	end
	logic capture;
	assign capture = is_cap && run_bit && cap_event;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= periodic_timer_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[1:0] == 2'h0) ?
					periodic_timer_pkg::RESP_OKAY :
					periodic_timer_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_ctl;
	logic wr_a;
	logic wr_p;
	assign wr_ctl = do_write && aw_addr == periodic_timer_pkg::OFF_CONTROL;
	assign wr_a = do_write && aw_addr == periodic_timer_pkg::OFF_COMPARE_A;
	assign wr_p = do_write && aw_addr == periodic_timer_pkg::OFF_COMPARE_P;

	////////////////////////////////////////////////////////////////////
	// Control register; rely on software not misprogramming
	always_ff @(posedge aclk) begin
		if (!aresetn)
			timer_control_one <= periodic_timer_pkg::CONTROL_RESET;
		else if (wr_ctl && w_strb[0])
			timer_control_one <= w_data[7:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			compare_p_value <= '0;
		else if (wr_p && w_strb[0])
			compare_p_value <= w_data[CNT_W-1:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			compare_a_value <= '0;
		else if (capture)
			compare_a_value <= count;
		else if (wr_a && w_strb[0])
			compare_a_value <= w_data[CNT_W-1:0];
	end

	// Run bit: software, external trigger, pulse end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_bit <= 1'b0;
			run_prev <= 1'b0;
		end else begin
			run_prev <= run_bit;
			if (is_pulse && !run_bit && ck_edges.rise)
				run_bit <= 1'b1;
			else if (is_pulse && match_a)
				run_bit <= 1'b0;
			else if (wr_ctl && w_strb[1])
				run_bit <= w_data[periodic_timer_pkg::POS_RUN];
		end
	end

	// Flags: set wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_a_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end else begin
			if (match_a || capture)
				match_a_flag <= 1'b1;
			else if (wr_ctl && w_strb[1] &&
				w_data[periodic_timer_pkg::POS_FLAG_A])
				match_a_flag <= 1'b0;
			if (match_p)
				match_p_flag <= 1'b1;
			else if (wr_ctl && w_strb[1] &&
				w_data[periodic_timer_pkg::POS_FLAG_P])
				match_p_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counter
	always_ff @(posedge aclk) begin
		if (!aresetn)
			count <= '0;
		else if (run_rise && is_pulse)
			count <= '0;
		else if (run_bit && count_tick) begin
			if (clear_cnt)
				count <= '0;
			else
				count <= count_inc;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output pin
	logic lvl;
	logic pwm_on;
	logic pwm_wave;
	logic [CNT_W:0] period;
	assign lvl = timer_control_one.out_init_level;
	assign period = (compare_p_value == '0) ? (CNT_W+1)'(1 << CNT_W) :
		{1'b0, compare_p_value};
	assign pwm_on = ({1'b0, compare_a_value} >= period) ||
		(count < compare_a_value);

	always_comb begin
		unique case (func)
			periodic_timer_pkg::FUNC_00: pwm_wave = ~lvl;
			periodic_timer_pkg::FUNC_01: pwm_wave = lvl;
			default: pwm_wave = pwm_on ? lvl : ~lvl;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pin_level <= 1'b0;
		else if (is_cmp) begin
			if (run_rise)
				pin_level <= lvl;
			else if (match_a) begin
				unique case (func)
					periodic_timer_pkg::FUNC_00: pin_level <= pin_level;
					periodic_timer_pkg::FUNC_01: pin_level <= 1'b0;
					periodic_timer_pkg::FUNC_10: pin_level <= 1'b1;
					periodic_timer_pkg::FUNC_11:
						pin_level <= ~pin_level;
				endcase
			end
		end else if (is_pwm)
			pin_level <= run_bit ? pwm_wave : ~lvl;
		else if (is_pulse)
			pin_level <= run_bit ? lvl : ~lvl;
		else
			pin_level <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			timer_io_pin_out <= 1'b0;
		else
			timer_io_pin_out <= pin_level ^ timer_control_one.out_invert;
	end

	assign timer_io_pin_oe = (mode == periodic_timer_pkg::MODE_COMPARE) ||
		(mode == periodic_timer_pkg::MODE_PWM);

	////////////////////////////////////////////////////////////////////
	// Read channel
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (s_axi_araddr)
			periodic_timer_pkg::OFF_CONTROL: begin
				rd_word[7:0] = timer_control_one;
				rd_word[periodic_timer_pkg::POS_RUN] = run_bit;
				rd_word[periodic_timer_pkg::POS_FLAG_A] = match_a_flag;
				rd_word[periodic_timer_pkg::POS_FLAG_P] = match_p_flag;
			end
			periodic_timer_pkg::OFF_COMPARE_A:
				rd_word[CNT_W-1:0] = compare_a_value;
			periodic_timer_pkg::OFF_COMPARE_P:
				rd_word[CNT_W-1:0] = compare_p_value;
			periodic_timer_pkg::OFF_COUNT: rd_word[CNT_W-1:0] = count;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= periodic_timer_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0) ?
				periodic_timer_pkg::RESP_OKAY :
				periodic_timer_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : periodic_timer

/* File: tb/periodic_timer_properties.sv */
/*
 * Bus handshake and pin timing checks of the periodic timer.
 * Bound to periodic_timer; sees its ports only.
 */
`timescale 1ns/1ps
module periodic_timer_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic count_tick,
	input wire logic timer_ext_clock_pin,
	input wire logic timer_io_pin_out,
	input wire logic timer_io_pin_oe
);
	logic [3:0] wr_age;
	logic [3:0] ev_age;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////
	// Cycles since the last write or timer event
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_wvalid && s_axi_wready))
			wr_age <= 4'h0;
		else if (wr_age != 4'hF)
			wr_age <= wr_age + 4'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_wvalid && s_axi_wready) || count_tick)
			ev_age <= 4'h0;
		else if ($changed(timer_ext_clock_pin))
			ev_age <= 4'h0;
		else if (ev_age != 4'hF)
			ev_age <= ev_age + 4'h1;
	end
	////////////////////////////////////////////////////////////////////
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_ar_ready;
		s_axi_arready == !s_axi_rvalid;
	endproperty
	a_ar_ready: assert property (p_ar_ready)
		else $error("arready not the inverse of rvalid");
	property p_b_after;
		s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after)
		else $error("write response late");
	property p_r_after;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_after: assert property (p_r_after)
		else $error("read data late");
	property p_w_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_busy: assert property (p_w_busy)
		else $error("write accepted while response pending");
	property p_pin_cause;
		$changed(timer_io_pin_out) |-> ev_age < 4'hA;
	endproperty
	a_pin_cause: assert property (p_pin_cause)
		else $error("pin moved without a cause");
	property p_oe_cause;
		$changed(timer_io_pin_oe) |-> wr_age < 4'h8;
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("pin enable moved without a write");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_pin: cover property ($rose(timer_io_pin_out));
endmodule : periodic_timer_properties

bind periodic_timer periodic_timer_properties u_periodic_timer_properties (
	.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.count_tick, .timer_ext_clock_pin, .timer_io_pin_out, .timer_io_pin_oe
);

/* File: tb/timer_pin_partner.sv */
/*
 * Pin side of the periodic timer: capture pin and external clock pin.
 * Assumes the timer's split pin output, enable and input.
 */
`timescale 1ns/1ps
module timer_pin_partner (
	input wire logic aclk,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_in,
	output logic ext_clk
);
	logic io_drive = 1'b0;
	initial ext_clk = 1'b0;
	// Wire level: timer wins while it drives
	assign pin_in = pin_oe ? pin_out : io_drive;
	task set_io(input logic v);
		@(posedge aclk);
		io_drive <= v;
	endtask : set_io
	task set_ext(input logic v);
		@(posedge aclk);
		ext_clk <= v;
	endtask : set_ext
endmodule : timer_pin_partner

/* File: tb/tb.sv */
/*
 * Self-checking bench of the periodic timer over AXI4-Lite.
 * Assumes the pin partner model and the bound checker.
 */
`timescale 1ns/1ps
module tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, count_tick;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, timer_io_pin_in, timer_ext_clock_pin;
	logic timer_io_pin_out, timer_io_pin_oe;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int error_cnt = 0, check_count = 0, cyc = 0;
	periodic_timer u_periodic_timer (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.count_tick, .timer_io_pin_in, .timer_ext_clock_pin,
		.timer_io_pin_out, .timer_io_pin_oe);
	timer_pin_partner u_timer_pin_partner (.aclk, .pin_out(timer_io_pin_out),
		.pin_oe(timer_io_pin_oe), .pin_in(timer_io_pin_in),
		.ext_clk(timer_ext_clock_pin));
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim;
		end
	end
	////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b0;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready)
				s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		rsp = s_axi_bresp;
	endtask : wr
	task rdr(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b0;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready)
				s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rdr
	task tk(input int n);
		repeat (n) begin
			count_tick <= 1'b1;
			@(posedge aclk);
			count_tick <= 1'b0;
			@(posedge aclk);
		end
	endtask : tk
	task ctl(input logic [1:0] m, f, input logic [3:0] b, input logic r);
		wr(periodic_timer_pkg::OFF_CONTROL, {21'h0, 2'b11, r, m, f, b});
	endtask : ctl
	task st(input logic [2:0] e);
		rdr(periodic_timer_pkg::OFF_CONTROL);
		chk(32'(rd[10:8]), 32'(e));
	endtask : st
	task cnt(input logic [9:0] e);
		rdr(periodic_timer_pkg::OFF_COUNT);
		chk(rd, 32'(e));
	endtask : cnt
	task pin(input logic e);
		chk(32'(timer_io_pin_out), 32'(e));
	endtask : pin
	task cfg(input logic [1:0] m, f, input logic [3:0] b,
		input logic [9:0] a, p, input logic go);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		wr(periodic_timer_pkg::OFF_COMPARE_A, {22'h0, a});
		wr(periodic_timer_pkg::OFF_COMPARE_P, {22'h0, p});
		ctl(m, f, b, 1'b0);
		if (go) ctl(m, f, b, 1'b1);
		// Pin follows the run bit two edges later
		repeat (2) @(posedge aclk);
	endtask : cfg
	////////////////////////////////////////////////////////////////////
	task t_reset;
		for (int i = 0; i < 4; i++) begin
			rdr(4'(i * 4));
			chk(rd, 32'h0);
		end
		wr(4'h2, 32'h000000FF);
		chk(32'(rsp), 32'(periodic_timer_pkg::RESP_SLVERR));
		rdr(4'h2);
		chk(32'(rsp), 32'(periodic_timer_pkg::RESP_SLVERR));
		rdr(periodic_timer_pkg::OFF_CONTROL);
		chk(rd, 32'h0);
		chk(32'(rsp), 32'(periodic_timer_pkg::RESP_OKAY));
		st(3'b000);
	endtask : t_reset
	task t_cmp;
		for (int f = 0; f < 4; f++) begin
			cfg(2'h0, 2'(f), 4'b1001, 10'h2, 10'h1, 1'b1);
			pin(1'b1);
			tk(2);
			st(3'b011);
			cnt(10'h0);
			pin(!f[0]);
		end
	endtask : t_cmp
	task t_ovf;
		cfg(periodic_timer_pkg::MODE_COMPARE, 2'h0, 4'h0, 10'h5, 10'h0, 1'b1);
		tk(5);
		cnt(10'h5);
		tk(1019);
		cnt(10'h0);
		st(3'b111);
	endtask : t_ovf
	task t_tmr;
		cfg(periodic_timer_pkg::MODE_TIMER, 2'h2, 4'h1, 10'h2, 10'h1, 1'b1);
		pin(1'b0);
		chk(32'(timer_io_pin_oe), 32'h0);
		tk(2);
		st(3'b011);
		cfg(periodic_timer_pkg::MODE_TIMER, 2'h0, 4'h0, 10'h0, 10'h0, 1'b1);
		tk(1023);
		cnt(10'h3FF);
		tk(1);
		cnt(10'h0);
		st(3'b101);
	endtask : t_tmr
	task t_pwm;
		int fa[4] = '{2, 2, 2, 0};
		int ba[4] = '{8, 8, 4, 0};
		int aa[4] = '{2, 5, 1, 1};
		int pa[4] = '{4, 4, 3, 3};
		int c;
		logic lv;
		for (int i = 0; i < 4; i++) begin
			cfg(2'h2, 2'(fa[i]), 4'(ba[i]), 10'(aa[i]), 10'(pa[i]), 1'b1);
			for (int k = 1; k < 8; k++) begin
				tk(1);
				c = k % pa[i];
				cnt(10'(c));
				lv = (fa[i] == 2) ? (aa[i] >= pa[i] || c < aa[i]) : fa[i] == 1;
				pin((lv ? ba[i][3] : !ba[i][3]) ^ ba[i][2]);
			end
			st({1'b1, aa[i] < pa[i], 1'b1});
		end
	endtask : t_pwm
	task t_pls;
		cfg(2'h2, 2'h3, 4'b1000, 10'h3, 10'h0, 1'b0);
		u_timer_pin_partner.set_ext(1'b1);
		repeat (8) @(posedge aclk);
		st(3'b001);
		pin(1'b1);
		tk(3);
		st(3'b010);
		pin(1'b0);
		cnt(10'h3);
		u_timer_pin_partner.set_ext(1'b0);
		ctl(2'h2, 2'h3, 4'b1000, 1'b1);
		cnt(10'h0);
		pin(1'b1);
	endtask : t_pls
	task t_cap;
		cfg(2'h1, 2'h0, 4'h0, 10'h0, 10'h6, 1'b1);
		tk(4);
		u_timer_pin_partner.set_io(1'b1);
		repeat (8) @(posedge aclk);
		rdr(periodic_timer_pkg::OFF_COMPARE_A);
		chk(rd, 32'h4);
		tk(2);
		cnt(10'h0);
		st(3'b111);
		u_timer_pin_partner.set_io(1'b0);
		ctl(2'h1, 2'h3, 4'h2, 1'b1);
		tk(1);
		u_timer_pin_partner.set_ext(1'b1);
		repeat (8) @(posedge aclk);
		rdr(periodic_timer_pkg::OFF_COMPARE_A);
		chk(rd, 32'h4);
		cnt(10'h1);
	endtask : t_cap
	task end_sim;
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, count_tick} = '0;
		{s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_cmp;
		t_ovf;
		t_tmr;
		t_pwm;
		t_pls;
		t_cap;
		end_sim;
	end
endmodule : tb
